/* File: hdl/i2cms_map.svh */
`ifndef I2CMS_MAP_SVH
`define I2CMS_MAP_SVH
// word indices, byte address is four times the index
`define I2CMS_IDX_DATA 12'hF50
`define I2CMS_IDX_STAT 12'hF51
`define I2CMS_IDX_CTL 12'hF52
`define I2CMS_IDX_IRQ_STAT 12'hF58
`define I2CMS_IDX_IRQ_MASK 12'hF59
// status bit positions
`define I2CMS_ST_TXE 7
`define I2CMS_ST_RXF 6
`define I2CMS_ST_ACK 5
`define I2CMS_ST_TEN 4
`define I2CMS_ST_RD 3
`define I2CMS_ST_ASP 2
`define I2CMS_ST_DSP 1
`define I2CMS_ST_NCK 0
// control bit positions
`define I2CMS_CT_EN 7
`define I2CMS_CT_START 6
`define I2CMS_CT_STOP 5
`define I2CMS_CT_TXI 3
// interrupt status and mask bits
`define I2CMS_IRQ_TX 0
`define I2CMS_IRQ_RX 1
`define I2CMS_IRQ_NCK 2
// reset values
`define I2CMS_RST_TXE 1'h1
`define I2CMS_RST_RXF 1'h0
`define I2CMS_RST_FLAG 1'h0
`define I2CMS_RST_BYTE 8'h00
`define I2CMS_RST_IRQ 3'h0
// ten-bit address prefix
`define I2CMS_TEN_PREFIX 5'h1E
`endif

/* File: hdl/i2cms_pkg.sv */
package i2cms_pkg;
  // events and levels from the shift engine
  typedef struct packed {
    logic addr_load;       // pulse: address loaded after start
    logic first_addr_sent; // pulse: first address byte out
    logic addr_shift;      // level: address bits shifting out
    logic data_shift;      // level: data bits shifting
    logic tx_load;         // pulse: holding byte taken
    logic rx_byte;         // pulse: byte received
    logic ack_valid;       // pulse: ack cycle finished
    logic ack_ok;          // ack result with ack_valid
    logic nack;            // pulse: nack sent or received
    logic start_done;      // pulse: start condition sent
    logic stop_done;       // pulse: stop condition sent
    logic [7:0] shift;     // shift register contents
    logic [7:0] rx_data;   // byte received with rx_byte
  } i2cms_eng_s;
  // control bits toward the shift engine
  typedef struct packed {
    logic enable;
    logic start;
    logic stop;
    logic tx_irq_enable;
    logic ack_stall;
    logic [7:0] tx_byte;
  } i2cms_ctl_s;
endpackage : i2cms_pkg

/* File: hdl/i2cms_status.sv */
// Our own choice: register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
`include "i2cms_map.svh"
module i2cms_status
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [15:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic dbg_read_i,
  input wire i2cms_pkg::i2cms_eng_s eng_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output i2cms_pkg::i2cms_ctl_s ctl_o,
  output logic irq_o
);

  // bus slave state
  logic done_reg; // request answered on the next edge
  logic [31:0] rdata_reg; // read data, latched one cycle early
  // registers
  logic [7:0] data_reg; // data holding register
  logic en_reg; // controller enable
  logic start_reg; // start request
  logic stop_reg; // stop request
  logic txi_reg; // tx interrupt enable
  // status flags
  logic txe_reg;
  logic rxf_reg;
  logic ack_reg;
  logic ten_reg;
  logic rd_reg;
  logic nck_reg;
  // ack result held while the write stall lasts
  logic pend_reg;
  logic pend_ok_reg;
  // interrupt sticky bits and mask
  logic [2:0] irq_st_reg;
  logic [2:0] irq_mask_reg;

  // address decode
  wire logic [11:0] word_idx = avs_address_i[13:2];
  wire logic addr_ok = (avs_address_i[15:14] == 2'h0) &&
                       (avs_address_i[1:0] == 2'h0);
  wire logic sel_data = addr_ok && (word_idx == `I2CMS_IDX_DATA);
  wire logic sel_stat = addr_ok && (word_idx == `I2CMS_IDX_STAT);
  wire logic sel_ctl = addr_ok && (word_idx == `I2CMS_IDX_CTL);
  wire logic sel_ist = addr_ok && (word_idx == `I2CMS_IDX_IRQ_STAT);
  wire logic sel_imk = addr_ok && (word_idx == `I2CMS_IDX_IRQ_MASK);
  // access takes effect only at the edge where waitrequest is low
  wire logic wr_fire = avs_write_i && done_reg && avs_byteenable_i[0];
  wire logic rd_fire = avs_read_i && done_reg;
  wire logic wr_data = wr_fire && sel_data;
  wire logic wr_ctl = wr_fire && sel_ctl;
  wire logic wr_ist = wr_fire && sel_ist;
  wire logic wr_imk = wr_fire && sel_imk;
  // debugger reads see the data but leave the flag alone
  wire logic rd_data_clr = rd_fire && sel_data && !dbg_read_i;
  wire logic [7:0] wbyte = avs_writedata_i[7:0];
  // software setting start or stop
  wire logic sw_start = wr_ctl && wbyte[`I2CMS_CT_START];
  wire logic sw_stop = wr_ctl && wbyte[`I2CMS_CT_STOP];

  // phase flags are straight views of the engine
  wire logic asp = eng_i.addr_shift;
  wire logic dsp = eng_i.data_shift;

  // status byte as software sees it
  wire logic [7:0] stat_byte = {txe_reg, rxf_reg, ack_reg, ten_reg,
                                rd_reg, asp, dsp, nck_reg};
  wire logic [7:0] ctl_byte = {en_reg, start_reg, stop_reg, 1'h0,
                               txi_reg, 3'h0};

  // read mux; unmapped words read zero, status holds no write path
  wire logic [7:0] rd_mux = sel_data ? data_reg :
                            sel_stat ? stat_byte :
                            sel_ctl ? ctl_byte :
                            sel_ist ? {5'h00, irq_st_reg} :
                            sel_imk ? {5'h00, irq_mask_reg} : 8'h00;

  // one wait state on every access
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !done_reg;
  assign avs_readdata_o = rdata_reg;

  // write stall: no next byte, write direction, no start or stop
  wire logic stall = en_reg && txe_reg && !rd_reg &&
                     !start_reg && !stop_reg;
  // ack result now usable: live one, or the held one after release
  wire logic ack_apply = (eng_i.ack_valid || pend_reg) && !stall;
  wire logic ack_val = eng_i.ack_valid ? eng_i.ack_ok : pend_ok_reg;

  // interrupt request levels
  wire logic tx_req = txe_reg && txi_reg && en_reg &&
                      !(dsp && rd_reg) &&
                      !(asp && rd_reg);
  wire logic rx_req = rxf_reg;
  wire logic nck_req = nck_reg;
  wire logic [2:0] irq_src = {nck_req, rx_req, tx_req};

  // ten-bit prefix check on the loaded address
  wire logic ten_hit = eng_i.addr_load &&
                       (eng_i.shift[7:3] == `I2CMS_TEN_PREFIX);
  // nack that counts: no start or stop pending
  wire logic nck_set = eng_i.nack && !start_reg && !stop_reg;

  // flag next values
  logic txe_next;
  logic rxf_next;
  logic ack_next;
  logic ten_next;
  logic rd_next;
  logic nck_next;
  logic pend_next;
  logic pend_ok_next;
  logic [2:0] irq_st_next;

  // tx empty: a new byte from software wins over the engine taking one
  always_comb
  begin
    txe_next = txe_reg;
    if (wr_data)
      txe_next = 1'h0;
    else if (eng_i.tx_load || !en_reg)
      txe_next = 1'h1;
  end

  // rx full: setting wins over a clearing read
  always_comb
  begin
    rxf_next = rxf_reg;
    if (en_reg && eng_i.rx_byte)
      rxf_next = 1'h1;
    else if (rd_data_clr)
      rxf_next = 1'h0;
  end

  // ack flag: only the ack result or disable touches it
  always_comb
  begin
    ack_next = ack_reg;
    if (!en_reg)
      ack_next = 1'h0;
    else if (ack_apply)
      ack_next = ack_val;
  end

  // ack result parked while stalled
  always_comb
  begin
    pend_next = pend_reg;
    pend_ok_next = pend_ok_reg;
    if (!en_reg)
      pend_next = 1'h0;
    else if (eng_i.ack_valid && stall)
    begin
      pend_next = 1'h1;
      pend_ok_next = eng_i.ack_ok;
    end
    else if (ack_apply)
      pend_next = 1'h0;
  end

  // ten-bit and direction flags, taken when the address loads
  always_comb
  begin
    ten_next = ten_reg;
    rd_next = rd_reg;
    if (eng_i.addr_load)
    begin
      ten_next = ten_hit;
      rd_next = eng_i.shift[0];
    end
    else if (eng_i.first_addr_sent)
      ten_next = 1'h0;
  end

  // nack flag: the set wins over a start or stop write
  always_comb
  begin
    nck_next = nck_reg;
    if (nck_set)
      nck_next = 1'h1;
    else if (sw_start || sw_stop)
      nck_next = 1'h0;
  end

  // sticky interrupt bits, write one to clear, source wins
  always_comb
  begin
    irq_st_next = irq_st_reg;
    if (wr_ist)
      irq_st_next = irq_st_reg & ~avs_writedata_i[2:0];
    irq_st_next = irq_st_next | irq_src;
  end

  // bus answer and read data
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      done_reg <= 1'h0;
    else
      done_reg <= (avs_read_i || avs_write_i) && !done_reg;
  end

  // read data latched in the wait cycle
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      rdata_reg <= 32'h00000000;
    else if (avs_read_i && !done_reg)
      rdata_reg <= {24'h000000, rd_mux};
  end

  // data holding register: software byte or received byte
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      data_reg <= `I2CMS_RST_BYTE;
    else if (eng_i.rx_byte && en_reg)
      data_reg <= eng_i.rx_data;
    else if (wr_data)
      data_reg <= wbyte;
  end

  // control bits; engine clears start and stop, software set wins
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      en_reg <= `I2CMS_RST_FLAG;
      start_reg <= `I2CMS_RST_FLAG;
      stop_reg <= `I2CMS_RST_FLAG;
      txi_reg <= `I2CMS_RST_FLAG;
    end
    else
    begin
      if (wr_ctl)
      begin
        en_reg <= wbyte[`I2CMS_CT_EN];
        txi_reg <= wbyte[`I2CMS_CT_TXI];
      end
      start_reg <= sw_start || (start_reg && !eng_i.start_done);
      stop_reg <= sw_stop || (stop_reg && !eng_i.stop_done);
    end
  end

  // status flags
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      txe_reg <= `I2CMS_RST_TXE;
      rxf_reg <= `I2CMS_RST_RXF;
      ack_reg <= `I2CMS_RST_FLAG;
      ten_reg <= `I2CMS_RST_FLAG;
      rd_reg <= `I2CMS_RST_FLAG;
      nck_reg <= `I2CMS_RST_FLAG;
    end
    else
    begin
      txe_reg <= txe_next;
      rxf_reg <= rxf_next;
      ack_reg <= ack_next;
      ten_reg <= ten_next;
      rd_reg <= rd_next;
      nck_reg <= nck_next;
    end
  end

  // parked ack result
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      pend_reg <= 1'h0;
      pend_ok_reg <= 1'h0;
    end
    else
    begin
      pend_reg <= pend_next;
      pend_ok_reg <= pend_ok_next;
    end
  end

  // interrupt status and mask
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      irq_st_reg <= `I2CMS_RST_IRQ;
      irq_mask_reg <= `I2CMS_RST_IRQ;
    end
    else
    begin
      irq_st_reg <= irq_st_next;
      if (wr_imk)
        irq_mask_reg <= avs_writedata_i[2:0];
    end
  end

  // level interrupt while any unmasked sticky bit stands
  assign irq_o = |(irq_st_reg & irq_mask_reg);

  // control toward the engine
  assign ctl_o.enable = en_reg;
  assign ctl_o.start = start_reg;
  assign ctl_o.stop = stop_reg;
  assign ctl_o.tx_irq_enable = txi_reg;
  assign ctl_o.ack_stall = stall;
  assign ctl_o.tx_byte = data_reg;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  AST_TXE_CLR: assert property (
    wr_data |=> !txe_reg)
    else $error("tx empty not cleared by data write");
  AST_TXE_SET: assert property (
    (eng_i.tx_load && !wr_data) |=> txe_reg)
    else $error("tx empty not set after byte taken");
  AST_TX_IRQ: assert property (
    (txe_reg && txi_reg && en_reg && !rd_reg) |=> irq_st_reg[0])
    else $error("tx request not raised");
  AST_RXF: assert property (
    (en_reg && eng_i.rx_byte) |=> rxf_reg ##1 irq_st_reg[1])
    else $error("rx full or request missing");
  AST_DBG_RD: assert property (
    (rd_fire && sel_data && dbg_read_i && rxf_reg) |=> rxf_reg)
    else $error("debugger read cleared rx full");
  AST_ACK_OFF: assert property (
    !en_reg |=> !ack_reg)
    else $error("ack flag kept while disabled");
  AST_ACK_HOLD: assert property (
    (en_reg && !eng_i.ack_valid && !pend_reg) |=> $stable(ack_reg))
    else $error("ack flag changed without ack result");
  AST_STALL: assert property (
    (stall && eng_i.ack_valid) |=> $stable(ack_reg) && pend_reg)
    else $error("ack updated during stall");
  AST_TEN: assert property (
    ten_hit |=> ten_reg)
    else $error("ten-bit flag not set");
  AST_RD: assert property (
    eng_i.addr_load |=> rd_reg == $past(eng_i.shift[0]))
    else $error("direction flag wrong");
  AST_NCK: assert property (
    nck_set |=> nck_reg ##1 irq_st_reg[2])
    else $error("nack flag or request missing");
  AST_NCK_KEEP: assert property (
    (nck_reg && !sw_start && !sw_stop) |=> nck_reg)
    else $error("nack flag cleared without start or stop");
  AST_BUS: assert property (
    (avs_read_i && !done_reg) |=> !avs_waitrequest_o)
    else $error("read not answered in one wait state");

endmodule : i2cms_status
`default_nettype wire

/* File: testbench/i2cms_eng_model.sv */
`timescale 1ns/10ps
`default_nettype none
// behavioural shift engine on the far side of the flags
module i2cms_eng_model
(
  input wire i2cms_pkg::i2cms_ctl_s ctl_i,
  input wire logic clk_sys_i,
  output i2cms_pkg::i2cms_eng_s eng_o
);
  initial eng_o = '0;
  // one engine step: pulses last one clock, levels stay
  task go(input i2cms_pkg::i2cms_eng_s p);
    i2cms_pkg::i2cms_eng_s q;
    q = '0;
    q.addr_shift = p.addr_shift;
    q.data_shift = p.data_shift;
    // stale bytes turn over, so a late sample is caught
    q.shift = ~p.shift;
    q.rx_data = ~p.rx_data;
    @(posedge clk_sys_i);
    eng_o <= p;
    @(posedge clk_sys_i);
    eng_o <= q;
  endtask : go
  // finish whichever condition software asked
  task done();
    i2cms_pkg::i2cms_eng_s p;
    p = '0;
    p.start_done = ctl_i.start;
    p.stop_done = ctl_i.stop;
    go(p);
  endtask : done
endmodule : i2cms_eng_model
`default_nettype wire

/* File: testbench/tb_i2c_master_status_flags.sv */
`timescale 1ns/10ps
`default_nettype none
`include "i2cms_map.svh"
module tb_i2c_master_status_flags;
  localparam logic [11:0] da = `I2CMS_IDX_DATA; // data
  localparam logic [11:0] st = `I2CMS_IDX_STAT; // status
  localparam logic [11:0] ct = `I2CMS_IDX_CTL; // control
  localparam logic [11:0] ir = `I2CMS_IDX_IRQ_STAT;
  localparam logic [11:0] im = `I2CMS_IDX_IRQ_MASK;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [15:0] avs_address_i = 16'h0000;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h00000000;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic dbg_read_i = 1'b0;
  i2cms_pkg::i2cms_eng_s eng_i;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  i2cms_pkg::i2cms_ctl_s ctl_o;
  logic irq_o;
  int n_fail = 0;
  int samples_checked = 0;
  i2cms_pkg::i2cms_eng_s e; // next engine step
  logic [7:0] v; // last byte read
  logic [7:0] b; // random byte
  logic [7:0] c; // control code
  always #5 clk_sys_i = ~clk_sys_i;
  i2cms_status uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .dbg_read_i(dbg_read_i),
    .eng_i(eng_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .ctl_o(ctl_o),
    .irq_o(irq_o));
  i2cms_eng_model eng (.ctl_i(ctl_o), .clk_sys_i(clk_sys_i),
    .eng_o(eng_i));
  // expected ten-bit and direction flags after an address load
  function logic [1:0] addr_exp(input logic [7:0] s);
    return {s[7:3] == `I2CMS_TEN_PREFIX, s[0]};
  endfunction : addr_exp
  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one transfer, held until waitrequest is seen low
  task bus(input logic w, input logic [11:0] a, input logic [7:0] d,
    input logic dbg);
    @(posedge clk_sys_i);
    avs_read_i <= ~w;
    avs_write_i <= w;
    avs_address_i <= {2'b00, a, 2'b00};
    avs_writedata_i <= {24'h000000, d};
    dbg_read_i <= dbg;
    do
      @(posedge clk_sys_i);
    while (avs_waitrequest_o !== 1'b0);
    v = avs_readdata_o[7:0];
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    dbg_read_i <= 1'b0;
  endtask : bus
  task wr(input logic [11:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 1'b0);
  endtask : wr
  task rd(input logic [11:0] a, input logic [7:0] x);
    bus(1'b0, a, 8'h00, 1'b0);
    chk(v, x);
  endtask : rd
  // read status and compare one flag
  task bt(input int p, input logic x);
    bus(1'b0, st, 8'h00, 1'b0);
    chk({7'h00, v[p]}, {7'h00, x});
  endtask : bt
  task results();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results
  // hang guard, far beyond the few hundred cycles needed
  initial
  begin
    #500000;
    n_fail++;
    results();
  end
  initial
  begin
    b = 8'($urandom(32'h2018));
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rd(st, 8'h80);
    wr(st, 8'h7F);
    rd(st, 8'h80);
    rd(12'h000, 8'h00);
    $display("test reset done");
    wr(ct, 8'h88);
    wr(im, 8'h07);
    // a write without its low byte lane must not reach the holding reg
    avs_byteenable_i <= 4'hE;
    wr(da, 8'h33);
    avs_byteenable_i <= 4'hF;
    rd(st, 8'h80);
    for (int i = 0; i < 4; i++)
    begin
      b = 8'($urandom);
      wr(da, b);
      rd(st, 8'h00);
      chk(ctl_o.tx_byte, b);
      chk({6'h00, ctl_o.enable, ctl_o.tx_irq_enable}, 8'h03);
      e = '0;
      e.tx_load = 1'b1;
      eng.go(e);
      rd(st, 8'h80);
      rd(ir, 8'h01);
    end
    $display("test transmit done");
    for (int i = 0; i < 4; i++)
    begin
      b = 8'($urandom);
      if (i[0])
        b[7:3] = 5'h1E;
      b[0] = i[1];
      e = '0;
      e.addr_load = 1'b1;
      e.addr_shift = 1'b1;
      e.shift = b;
      eng.go(e);
      bus(1'b0, st, 8'h00, 1'b0);
      chk({5'h00, v[4:2]}, {5'h00, addr_exp(b), 1'b1});
      wr(ir, 8'h07);
      rd(ir, {7'h00, ~b[0]});
      e = '0;
      e.first_addr_sent = 1'b1;
      e.data_shift = 1'b1;
      eng.go(e);
      bt(4, 1'b0);
      chk({6'h00, v[2:1]}, 8'h01);
      wr(ir, 8'h07);
      rd(ir, {7'h00, ~b[0]});
    end
    $display("test address done");
    wr(ct, 8'h80);
    wr(im, 8'h02);
    wr(ir, 8'h07);
    for (int i = 0; i < 3; i++)
    begin
      b = 8'($urandom);
      e = '0;
      e.rx_byte = 1'b1;
      e.rx_data = b;
      eng.go(e);
      bt(6, 1'b1);
      chk({7'h00, irq_o}, 8'h01);
      bus(1'b0, da, 8'h00, 1'b1);
      chk(v, b);
      bt(6, 1'b1);
      rd(da, b);
      bt(6, 1'b0);
      // drop the sticky bit so the next pass sees a fresh request
      wr(ir, 8'h02);
      rd(ir, 8'h00);
      chk({7'h00, irq_o}, 8'h00);
    end
    $display("test receive done");
    e = '0;
    e.addr_load = 1'b1;
    eng.go(e);
    wr(da, 8'h5A);
    e = '0;
    e.ack_valid = 1'b1;
    e.ack_ok = 1'b1;
    eng.go(e);
    bt(5, 1'b1);
    bt(5, 1'b1);
    e = '0;
    e.addr_load = 1'b1;
    eng.go(e);
    bt(5, 1'b1);
    e = '0;
    e.tx_load = 1'b1;
    eng.go(e);
    e = '0;
    e.ack_valid = 1'b1;
    eng.go(e);
    bt(5, 1'b1);
    chk({7'h00, ctl_o.ack_stall}, 8'h01);
    wr(da, 8'hA5);
    bt(5, 1'b0);
    chk({7'h00, ctl_o.ack_stall}, 8'h00);
    e.ack_ok = 1'b1;
    eng.go(e);
    bt(5, 1'b1);
    wr(ct, 8'h00);
    bt(5, 1'b0);
    $display("test acknowledge done");
    wr(ct, 8'h80);
    wr(im, 8'h04);
    e = '0;
    e.nack = 1'b1;
    eng.go(e);
    bt(0, 1'b1);
    chk({7'h00, irq_o}, 8'h01);
    wr(ir, 8'h07);
    bt(0, 1'b1);
    for (int i = 0; i < 2; i++)
    begin
      c = i[0] ? 8'hA0 : 8'hC0;
      wr(ct, c);
      bt(0, 1'b0);
      chk({6'h00, ctl_o.start, ctl_o.stop}, {6'h00, c[6:5]});
      eng.go(e);
      bt(0, 1'b0);
      eng.done();
      // the clearing edge is the one the model returns on; look after it
      @(posedge clk_sys_i);
      chk({6'h00, ctl_o.start, ctl_o.stop}, 8'h00);
      eng.go(e);
      bt(0, 1'b1);
    end
    $display("test nack done");
    results();
  end
endmodule : tb_i2c_master_status_flags
`default_nettype wire
